// [src/bdt_timing_regs.sv]
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
module bdt_timing_regs #(
    parameter int ADDR_W = 8,
    parameter logic [2:0] SET3_BLANK_CODE = 3'h4,
    parameter logic [2:0] SET4_DEAD_CODE = 3'h4,
    parameter logic [2:0] SET4_BLANK_CODE = 3'h4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] hb_cmd,
    input wire logic [3:0] vds_comp,
    output logic [3:0] hs_gate,
    output logic [3:0] ls_gate,
    output logic [3:0] vds_fault
);

    bdt_pkg::bdt_state_type s_q;
    bdt_pkg::bdt_state_type s_d;

    always_comb
    begin
        logic setup;
        logic access;
        logic [4:0] idx;
        logic upper_ok;
        logic mapped;
        logic [31:0] rd;
        logic [1:0] sel;
        logic [1:0] want;
        logic [2:0] dcode;
        logic [2:0] bcode;
        logic [bdt_pkg::CNT_W-1:0] dcyc;
        logic [bdt_pkg::CNT_W-1:0] bcyc;
        setup = 1'b0;
        access = 1'b0;
        idx = 5'h00;
        upper_ok = 1'b0;
        mapped = 1'b0;
        rd = 32'h0000_0000;
        sel = 2'h0;
        want = 2'h0;
        dcode = 3'h0;
        bcode = 3'h0;
        dcyc = '0;
        bcyc = '0;
        s_d = s_q;

        // Pins are asynchronous: two flops first
        s_d.cmd_m = hb_cmd;
        s_d.cmd_s = s_q.cmd_m;
        s_d.comp_m = vds_comp;
        s_d.comp_s = s_q.comp_m;

        setup = psel & ~penable;
        access = psel & penable & s_q.pready;
        idx = paddr[6:2];
        upper_ok = (paddr >> 7) == '0;
        mapped = upper_ok && (paddr[1:0] == 2'h0) &&
                 (idx == bdt_pkg::SEL_IDX || idx == bdt_pkg::ACT_IDX ||
                  idx == bdt_pkg::BANK_IDX);

        if (idx == bdt_pkg::SEL_IDX)
        begin
            rd = {24'h000000, s_q.sel};
        end
        else if (idx == bdt_pkg::ACT_IDX && !s_q.bank)
        begin
            rd = {17'h00000, s_q.act};
        end
        else if (idx == bdt_pkg::ACT_IDX)
        begin
            rd = {17'h00000, s_q.fw};
        end
        else if (idx == bdt_pkg::BANK_IDX)
        begin
            rd = {31'h00000000, s_q.bank};
        end

        // Answer is prepared in setup so every output leaves a flop
        s_d.pready = setup;
        s_d.pslverr = setup & ~mapped;
        if (setup)
        begin
            s_d.prdata = mapped ? rd : 32'h0000_0000;
        end

        if (access && pwrite && !s_q.pslverr)
        begin
            if (idx == bdt_pkg::SEL_IDX)
            begin
                s_d.sel = pwdata[bdt_pkg::SEL_USED_W-1:0];
            end
            // active copy only in bank 0
            else if (idx == bdt_pkg::ACT_IDX && !s_q.bank)
            begin
                s_d.act = pwdata[bdt_pkg::TIM_USED_W-1:0];
            end
            else if (idx == bdt_pkg::ACT_IDX)
            begin
                s_d.fw = pwdata[bdt_pkg::TIM_USED_W-1:0];
            end
            else
            begin
                s_d.bank = pwdata[0];
            end
        end

        for (int b = 0; b < bdt_pkg::NUM_BRIDGES; b++)
        begin
            sel = s_q.sel[b*bdt_pkg::SEL_FLD_W +: bdt_pkg::SEL_FLD_W];
            want = s_q.cmd_s[2*b +: 2];
            unique case (sel)
                2'h0:
                begin
                    dcode = s_q.act[bdt_pkg::DEAD1_LSB +: bdt_pkg::CODE_W];
                    bcode = s_q.act[bdt_pkg::BLANK1_LSB +: bdt_pkg::CODE_W];
                end
                2'h1:
                begin
                    dcode = s_q.act[bdt_pkg::DEAD2_LSB +: bdt_pkg::CODE_W];
                    bcode = s_q.act[bdt_pkg::BLANK2_LSB +: bdt_pkg::CODE_W];
                end
                2'h2:
                begin
                    dcode = s_q.act[bdt_pkg::DEAD3_LSB +: bdt_pkg::CODE_W];
                    bcode = SET3_BLANK_CODE;
                end
                2'h3:
                begin
                    dcode = SET4_DEAD_CODE;
                    bcode = SET4_BLANK_CODE;
                end
            endcase
            dcyc = bdt_pkg::bdt_ns2cyc(bdt_pkg::DEAD_NS[dcode]);
            bcyc = bdt_pkg::bdt_ns2cyc(bdt_pkg::BLANK_NS[bcode]);

            if (s_q.br[b].blank_cnt != '0)
            begin
                s_d.br[b].blank_cnt = s_q.br[b].blank_cnt - 1'b1;
            end

            // Command 00 and reserved 11 mean both gates off
            unique case (s_q.br[b].state)
                bdt_pkg::BR_OFF:
                begin
                    if (want == 2'h1 || want == 2'h2)
                    begin
                        s_d.br[b].state = bdt_pkg::BR_ON;
                        s_d.br[b].hs_on = want[1];
                        s_d.br[b].ls_on = want[0];
                        s_d.br[b].want_hs = want[1];
                        s_d.br[b].blank_cnt = bcyc;
                    end
                end
                bdt_pkg::BR_ON:
                begin
                    if (want != {s_q.br[b].hs_on, s_q.br[b].ls_on})
                    begin
                        s_d.br[b].hs_on = 1'b0;
                        s_d.br[b].ls_on = 1'b0;
                        s_d.br[b].blank_cnt = '0;
                        if (want == 2'h1 || want == 2'h2)
                        begin
                            s_d.br[b].state = bdt_pkg::BR_DEAD;
                            s_d.br[b].dead_cnt = dcyc;
                            s_d.br[b].want_hs = want[1];
                        end
                        else
                        begin
                            s_d.br[b].state = bdt_pkg::BR_OFF;
                        end
                    end
                end
                bdt_pkg::BR_DEAD:
                begin
                    if (want != 2'h1 && want != 2'h2)
                    begin
                        s_d.br[b].state = bdt_pkg::BR_OFF;
                    end
                    else if (s_q.br[b].dead_cnt <= 1)
                    begin
                        s_d.br[b].state = bdt_pkg::BR_ON;
                        s_d.br[b].hs_on = want[1];
                        s_d.br[b].ls_on = want[0];
                        s_d.br[b].want_hs = want[1];
                        s_d.br[b].blank_cnt = bcyc;
                    end
                    else
                    begin
                        s_d.br[b].dead_cnt = s_q.br[b].dead_cnt - 1'b1;
                    end
                end
                default:
                begin
                    s_d.br[b].state = bdt_pkg::BR_OFF;
                    s_d.br[b].hs_on = 1'b0;
                    s_d.br[b].ls_on = 1'b0;
                end
            endcase

            s_d.br[b].fault = s_q.comp_s[b] &&
                              (s_q.br[b].state == bdt_pkg::BR_ON) &&
                              (s_q.br[b].blank_cnt == '0);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
            s_q.sel <= bdt_pkg::SEL_RST;
            s_q.act <= bdt_pkg::TIM_RST;
            s_q.fw <= bdt_pkg::TIM_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;

    genvar g;
    generate
        for (g = 0; g < bdt_pkg::NUM_BRIDGES; g++)
        begin : g_out
            assign hs_gate[g] = s_q.br[g].hs_on;
            assign ls_gate[g] = s_q.br[g].ls_on;
            assign vds_fault[g] = s_q.br[g].fault;
        end
    endgenerate

endmodule

// [src/bdt_pkg.sv]
// Summary of operation
// - Two-bit bridge selector: 00 picks set 1, 01 set 2, 10 set 3, 11 set 4.
// - Selector fields: bridge 1 bits 1:0, 2 at 3:2, 3 at 5:4, 4 at 7:6.
// - Selector bits 15:8 and timing bit 15 are read-only and read zero.
// - Selector register at index 0x04 resets to zero, so all bridges use set 1.
// - Active timing register at index 0x05 is reached only while bank is zero.
// - Timing fields: dead1 2:0, blank1 5:3, dead2 8:6, blank2 11:9, dead3 14:12.
// - Each timing field resets to 100, two microseconds; register resets 0x4924.
// - Dead codes give 375ns,625ns,1us,1.5us,2us,3us,4us,16us.
// - Blank codes give 625ns,1us,1.25us,1.5us,2us,3us,4us,16us.
// - Freewheeling copy shares index 0x05, same layout, reached while bank is one.
package bdt_pkg;

    localparam int CLK_MHZ = 40;
    localparam int CNT_W = 10;
    localparam int NUM_BRIDGES = 4;

    localparam logic [4:0] SEL_IDX = 5'h04;
    localparam logic [4:0] ACT_IDX = 5'h05;
    localparam logic [4:0] BANK_IDX = 5'h1f;

    localparam int SEL_USED_W = 8;
    localparam int TIM_USED_W = 15;
    localparam int SEL_FLD_W = 2;
    localparam int CODE_W = 3;

    localparam int DEAD1_LSB = 0;
    localparam int BLANK1_LSB = 3;
    localparam int DEAD2_LSB = 6;
    localparam int BLANK2_LSB = 9;
    localparam int DEAD3_LSB = 12;

    localparam logic [SEL_USED_W-1:0] SEL_RST = 8'h00;
    localparam logic [TIM_USED_W-1:0] TIM_RST = 15'h4924;
    localparam logic [2:0] CODE_RST = 3'h4;

    localparam int DEAD_NS [8] = '{375, 625, 1000, 1500, 2000, 3000, 4000,
                                   16000};
    localparam int BLANK_NS [8] = '{625, 1000, 1250, 1500, 2000, 3000, 4000,
                                    16000};

    // Least times: round up to whole cycles
    function automatic logic [CNT_W-1:0] bdt_ns2cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        if (c < 1)
        begin
            c = 1;
        end
        return c[CNT_W-1:0];
    endfunction

    typedef enum logic [1:0] {
        BR_OFF,
        BR_DEAD,
        BR_ON
    } bdt_br_state_type;

    typedef struct packed {
        bdt_br_state_type state;
        logic hs_on;
        logic ls_on;
        logic want_hs;
        logic [CNT_W-1:0] dead_cnt;
        logic [CNT_W-1:0] blank_cnt;
        logic fault;
    } bdt_bridge_type;

    typedef struct packed {
        logic [SEL_USED_W-1:0] sel;
        logic [TIM_USED_W-1:0] act;
        logic [TIM_USED_W-1:0] fw;
        logic bank;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [2*NUM_BRIDGES-1:0] cmd_m;
        logic [2*NUM_BRIDGES-1:0] cmd_s;
        logic [NUM_BRIDGES-1:0] comp_m;
        logic [NUM_BRIDGES-1:0] comp_s;
        bdt_bridge_type [NUM_BRIDGES-1:0] br;
    } bdt_state_type;

endpackage

// [testbench/bdt_checker.sv]
`timescale 1ns/10ps
module bdt_checker #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] hb_cmd,
    input wire logic [3:0] vds_comp,
    input wire logic [3:0] hs_gate,
    input wire logic [3:0] ls_gate,
    input wire logic [3:0] vds_fault
);
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    rdy_after_setup_a: assert property (
        psel && !penable |=> pready) else $error("ready late");
    rdy_single_a: assert property (
        pready |=> !pready) else $error("ready too long");
    map_err_a: assert property (
        pready |-> pslverr == !(paddr inside {8'h10, 8'h14, 8'h7c}))
        else $error("bad error flag");
    resv_sel_a: assert property (
        pready && !pwrite && paddr == 8'h10 |-> prdata[31:8] == 24'h0)
        else $error("selector high bits set");
    resv_tim_a: assert property (
        pready && !pwrite && paddr == 8'h14 |-> prdata[31:15] == 17'h0)
        else $error("timing high bits set");
    no_overlap_a: assert property (
        (hs_gate & ls_gate) == 4'h0) else $error("both gates on");
    no_swap_a: assert property (
        ((hs_gate & $past(ls_gate)) | (ls_gate & $past(hs_gate))) == 4'h0)
        else $error("swap without gap");
    blank_mask_a: assert property (
        $rose(hs_gate[0] | ls_gate[0]) |-> !vds_fault[0] [*8])
        else $error("fault inside blank");
    off_cmd_a: assert property (
        (hb_cmd[1:0] == 2'b00) [*5] |-> !hs_gate[0] && !ls_gate[0])
        else $error("gate on while off");
    cover property (pready && pslverr);
    cover property ($rose(ls_gate[0]));
    cover property ($rose(vds_fault[3]));
endmodule

bind bdt_timing_regs bdt_checker #(.ADDR_W(ADDR_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hb_cmd(hb_cmd), .vds_comp(vds_comp), .hs_gate(hs_gate),
    .ls_gate(ls_gate), .vds_fault(vds_fault)
);

// [testbench/bdt_stage_model.sv]
`timescale 1ns/10ps
module bdt_stage_model (
    input wire logic [3:0] hs_gate,
    input wire logic [3:0] ls_gate,
    input wire logic [3:0] short_en,
    output logic [3:0] vds_comp
);
    // Shorted load: drop stays high while on
    assign vds_comp = (hs_gate | ls_gate) & short_en;
endmodule

// [testbench/bridge_deadtime_blank_config_tb.sv]
`timescale 1ns/10ps
`define CHK(a, e) \
begin \
    n_tests++; \
    if ((a) !== (e)) \
    begin \
        miscompares++; \
        $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); \
    end \
end
module bridge_deadtime_blank_config_tb;
    localparam logic [2:0] S3B = 3'h1;
    localparam logic [2:0] S4D = 3'h6;
    localparam logic [2:0] S4B = 3'h5;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] hb_cmd = 8'h00;
    logic [3:0] vds_comp;
    logic [3:0] hs_gate;
    logic [3:0] ls_gate;
    logic [3:0] vds_fault;
    logic [3:0] short_en = 4'h0;
    int miscompares = 0;
    int n_tests = 0;
    int dcyc [8] = '{15, 25, 40, 60, 80, 120, 160, 640};
    int bcyc [8] = '{25, 40, 50, 60, 80, 120, 160, 640};
    always #12.5 pclk = ~pclk;
    bdt_timing_regs #(.SET3_BLANK_CODE(S3B), .SET4_DEAD_CODE(S4D),
        .SET4_BLANK_CODE(S4B)) dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hb_cmd(hb_cmd), .vds_comp(vds_comp), .hs_gate(hs_gate),
        .ls_gate(ls_gate), .vds_fault(vds_fault));
    bdt_stage_model stage (.hs_gate(hs_gate), .ls_gate(ls_gate),
        .short_en(short_en), .vds_comp(vds_comp));
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [31:0] x, input logic xe);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
            n++;
            if (n > 16)
            begin
                miscompares++;
                tally_and_finish();
            end
        end
        if (!w)
        begin
            `CHK(prdata, x)
        end
        `CHK(pslverr, xe)
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic probe(input int k, input int b);
        case (k)
            0: return hs_gate[b];
            1: return !hs_gate[b];
            2: return ls_gate[b];
            default: return vds_fault[b];
        endcase
    endfunction
    task automatic wait_probe(input int k, input int b, output int n);
        n = 0;
        while (probe(k, b) !== 1'b1)
        begin
            @(posedge pclk);
            n++;
            if (n > 800)
            begin
                miscompares++;
                tally_and_finish();
            end
        end
    endtask
    task automatic run_bridge(input int b, input int xd, input int xb);
        int n;
        @(posedge pclk);
        hb_cmd[2*b +: 2] <= 2'b10;
        wait_probe(0, b, n);
        hb_cmd[2*b +: 2] <= 2'b01;
        wait_probe(1, b, n);
        wait_probe(2, b, n);
        `CHK(n >= xd && n <= xd + 2, 1'b1)
        wait_probe(3, b, n);
        `CHK(n >= xb && n <= xb + 4, 1'b1)
        hb_cmd[2*b +: 2] <= 2'b00;
        repeat (8) @(posedge pclk);
    endtask
    task automatic t_regs();
        apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 8'h14, 32'h0, 32'h4924, 1'b0);
        apb(1'b1, 8'h10, 32'hffff_ff1b, 32'h0, 1'b0);
        apb(1'b0, 8'h10, 32'h0, 32'h1b, 1'b0);
        apb(1'b1, 8'h14, 32'hffff_ffff, 32'h0, 1'b0);
        apb(1'b0, 8'h14, 32'h0, 32'h7fff, 1'b0);
        apb(1'b1, 8'h7c, 32'h1, 32'h0, 1'b0);
        apb(1'b1, 8'h14, 32'h0aaa, 32'h0, 1'b0);
        apb(1'b0, 8'h14, 32'h0, 32'h0aaa, 1'b0);
        apb(1'b1, 8'h7c, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 8'h14, 32'h0, 32'h7fff, 1'b0);
        apb(1'b1, 8'h40, 32'h1, 32'h0, 1'b1);
        apb(1'b0, 8'h18, 32'h0, 32'h0, 1'b1);
        $display("register test done");
    endtask
    task automatic t_timing();
        int sd [4] = '{0, 1, 3, int'(S4D)};
        int sb [4] = '{0, 2, int'(S3B), int'(S4B)};
        short_en <= 4'hf;
        apb(1'b1, 8'h10, 32'h0, 32'h0, 1'b0);
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, 8'h14, 32'(c * 9), 32'h0, 1'b0);
            run_bridge(c % 4, dcyc[c], bcyc[c]);
        end
        apb(1'b1, 8'h14, 32'h3440, 32'h0, 1'b0);
        for (int s = 1; s < 4; s++)
        begin
            apb(1'b1, 8'h10, 32'(s << (2 * s)), 32'h0, 1'b0);
            run_bridge(s, dcyc[sd[s]], bcyc[sb[s]]);
        end
        $display("timing test done");
    endtask
    task automatic t_reserved();
        int n;
        @(posedge pclk);
        hb_cmd[7:6] <= 2'b01;
        wait_probe(2, 3, n);
        // Long set 4 dead time leaves room to abort
        hb_cmd[7:6] <= 2'b10;
        repeat (8) @(posedge pclk);
        `CHK({hs_gate[3], ls_gate[3]}, 2'b00)
        hb_cmd[7:6] <= 2'b11;
        repeat (dcyc[S4D] + 8) @(posedge pclk);
        `CHK({hs_gate[3], ls_gate[3]}, 2'b00)
        hb_cmd[7:6] <= 2'b00;
        repeat (8) @(posedge pclk);
        $display("reserved command test done");
    endtask
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_timing();
        t_reserved();
        tally_and_finish();
    end
endmodule
